// >>> cfg_loader_consts.vh
`ifndef CFG_LOADER_CONSTS_VH
`define CFG_LOADER_CONSTS_VH

// ----------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------
`define MCLK_PERIOD_NS   20
`define CCLK_SETUP_NS    20
`define CCLK_HIGH_NS     20
`define CCLK_HOLD_NS     20
`define CCLK_SETUP_CYC   ((`CCLK_SETUP_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define CCLK_HIGH_CYC    ((`CCLK_HIGH_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define CCLK_HOLD_CYC    ((`CCLK_HOLD_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define SETTLE_DONE      2'h3

// ----------------------------------------------------------------
// parallel port data line positions
// ----------------------------------------------------------------
`define PPD_STROBE_BIT   0
`define PPD_NYB_LO       2
`define PPD_NYB_HI       5
`define PPD_PROG_BIT     7

// ----------------------------------------------------------------
// fpga pin positions, fixed levels and sizes
// ----------------------------------------------------------------
`define DP_SEG_BIT       1
`define PPD_INV_MASK     8'h03
`define MODE_SLAVE_PAR   1'h0
`define FIFO_DEPTH       8
`define SYNC_WIDTH       14

`endif

// >>> pin_sync.v
`timescale 1ns/1ps

// ----------------------------------------------------------------
// two-stage synchroniser for a group of pin levels
// ----------------------------------------------------------------
module pin_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             mclk_in,
  input  wire             rst_in,
  // asynchronous levels in, synchronised levels out
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage1;

  // first stage is read only by the second
  always @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      stage1   <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule // pin_sync

// >>> byte_fifo.v
`timescale 1ns/1ps

// ----------------------------------------------------------------
// synchronous fifo with valid/ready on both sides
// ----------------------------------------------------------------
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // clock, reset, flush
  input  wire             mclk_in,
  input  wire             rst_in,
  input  wire             flush_in,
  // fill side
  input  wire             in_valid_in,
  output wire             in_ready_out,
  input  wire [WIDTH-1:0] in_data_in,
  // drain side
  output wire             out_valid_out,
  input  wire             out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr;
  reg [AW:0]      rd_ptr;
  wire [AW:0]     level;
  wire            push;
  wire            pop;

  // occupancy and handshakes
  assign level         = wr_ptr - rd_ptr;
  assign in_ready_out  = (level != DEPTH[AW:0]);
  assign out_valid_out = (level != {(AW+1){1'b0}});
  assign out_data_out  = mem[rd_ptr[AW-1:0]];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  // storage
  always @(posedge mclk_in)
  begin
    if (push)
      mem[wr_ptr[AW-1:0]] <= in_data_in;
  end

  // pointers
  always @(posedge mclk_in)
  begin
    if (rst_in || flush_in)
    begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr <= wr_ptr + {{AW{1'b0}}, 1'b1};
      if (pop)
        rd_ptr <= rd_ptr + {{AW{1'b0}}, 1'b1};
    end
  end

endmodule // byte_fifo

// >>> cfg_loader.v
// Contract
// - hold fpga boundary-scan clock low always
// - flash enable high until done, then released
// - mode select pin driven low always
// - reconfig request follows data line D7
// - chip-select, write strobe low until done
// - byte sent as two nybbles, upper first
// - upper nybble captured on D0 falling edge
// - data pins show buffered byte, lower half taken on D0 rising
// - fpga config clock rises on D0 rising
// - stop driving config data once done
// - after done, flash off: light decimal point only
// - after done, flash on: release all lines
// - forward data lines, low two inverted, gated
// - three fpga outputs onto status lines
// - one status line carries own test-data-out
// - oscillator forwarded unchanged to fpga clock
`timescale 1ns/1ps
`include "cfg_loader_consts.vh"

module cfg_loader #(
  parameter SETUP_CYC = `CCLK_SETUP_CYC,
  parameter HIGH_CYC  = `CCLK_HIGH_CYC,
  parameter HOLD_CYC  = `CCLK_HOLD_CYC,
  parameter DEPTH     = `FIFO_DEPTH
) (
  // clock and reset
  input  wire       mclk_in,
  input  wire       rst_in,
  // parallel port
  input  wire [7:0] ppd_in,
  output reg  [2:0] pps_out,
  output reg        pps_tdo_out,
  // own boundary-scan test data out
  input  wire       jtag_tdo_in,
  // oscillator
  input  wire       osc_in,
  output wire       fpga_clk_out,
  // fpga configuration pins
  output reg        fpga_tck_out,
  output reg        fpga_cclk_out,
  output reg        fpga_progb_out,
  output reg        fpga_csb_out,
  output reg        fpga_csb_oe_out,
  output reg        fpga_wrb_out,
  output reg        fpga_wrb_oe_out,
  output reg        config_mode_select_out,
  input  wire       fpga_done_in,
  // fpga data pins, shared with led segments
  output reg  [7:0] fpga_d_out,
  output reg  [7:0] fpga_d_oe_out,
  // fpga general-purpose pins
  output reg  [7:0] fpga_ppd_out,
  output reg        fpga_ppd_oe_out,
  input  wire [2:0] fpga_pps_in,
  // flash chip-enable, two-way
  input  wire       fceb_in,
  output reg        fceb_out,
  output reg        fceb_oe_out,
  // loader status
  output reg        busy_out,
  output reg        overrun_out
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam ST_IDLE  = 2'h0;
  localparam ST_SETUP = 2'h1;
  localparam ST_HIGH  = 2'h2;
  localparam ST_HOLD  = 2'h3;

  wire [13:0] sync_bus;
  wire [7:0]  ppd_s;
  wire        done_s;
  wire        fceb_s;
  wire [2:0]  pps_s;
  wire        tdo_s;
  reg         strobe_prev;
  reg  [1:0]  settle;
  wire        sync_ok;
  wire        strobe_fall;
  wire        strobe_rise;
  reg  [3:0]  upper_nyb;
  reg  [7:0]  pend_byte;
  reg         pend_valid;
  wire        fifo_in_ready;
  wire        fifo_out_valid;
  wire [7:0]  fifo_out_data;
  reg         fifo_pop;
  wire        flush;
  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [3:0]  cnt;
  reg  [3:0]  next_cnt;
  reg  [7:0]  cfg_byte;
  reg  [7:0]  next_cfg_byte;
  reg         next_cclk;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  pin_sync #(
    .WIDTH (`SYNC_WIDTH)
  ) u_sync (
    .mclk_in  (mclk_in),
    .rst_in   (rst_in),
    .async_in ({jtag_tdo_in, fpga_pps_in, fceb_in, fpga_done_in, ppd_in}),
    .sync_out (sync_bus)
  );

  // split the synchronised group
  assign ppd_s  = sync_bus[7:0];
  assign done_s = sync_bus[8];
  assign fceb_s = sync_bus[9];
  assign pps_s  = sync_bus[12:10];
  assign tdo_s  = sync_bus[13];

  // ----------------------------------------------------------------
  // strobe edge detection
  // ----------------------------------------------------------------

  // pin levels trusted once both sync stages refilled after reset
  always @(posedge mclk_in)
  begin
    if (rst_in)
      settle <= 2'h0;
    else if (!sync_ok)
      settle <= settle + 2'h1;
  end

  assign sync_ok = (settle == `SETTLE_DONE);

  // previous strobe level, taken from the second stage
  always @(posedge mclk_in)
  begin
    if (rst_in)
      strobe_prev <= 1'b1;
    else
      strobe_prev <= ppd_s[`PPD_STROBE_BIT];
  end

  // strobe edges follow D0 directly, not inverted, gated by sync_ok
  assign strobe_fall = sync_ok & strobe_prev & ~ppd_s[`PPD_STROBE_BIT];
  assign strobe_rise = sync_ok & ~strobe_prev & ppd_s[`PPD_STROBE_BIT];

  // ----------------------------------------------------------------
  // nybble assembly
  // ----------------------------------------------------------------

  // upper half captured on D0 falling edge
  always @(posedge mclk_in)
  begin
    if (rst_in)
      upper_nyb <= 4'h0;
    else if (strobe_fall)
      upper_nyb <= ppd_s[`PPD_NYB_HI:`PPD_NYB_LO];
  end

  // whole byte formed on D0 rising edge, held until fifo takes it
  always @(posedge mclk_in)
  begin
    if (rst_in || flush)
    begin
      pend_byte  <= 8'h00;
      pend_valid <= 1'b0;
    end
    else if (strobe_rise)
    begin
      pend_byte  <= {upper_nyb, ppd_s[`PPD_NYB_HI:`PPD_NYB_LO]};
      pend_valid <= 1'b1;
    end
    else if (fifo_in_ready)
      pend_valid <= 1'b0;
  end

  // byte lost when a new one arrives while the last is still held
  always @(posedge mclk_in)
  begin
    if (rst_in || ~ppd_s[`PPD_PROG_BIT])
      overrun_out <= 1'b0;
    else if (strobe_rise && pend_valid && !fifo_in_ready)
      overrun_out <= 1'b1;
  end

  // a new configuration or completion discards buffered bytes
  assign flush = ~sync_ok | ~ppd_s[`PPD_PROG_BIT] | done_s;

  // ----------------------------------------------------------------
  // byte buffer
  // ----------------------------------------------------------------
  byte_fifo #(
    .WIDTH (8),
    .DEPTH (DEPTH),
    .AW    (3)
  ) u_fifo (
    .mclk_in       (mclk_in),
    .rst_in        (rst_in),
    .flush_in      (flush),
    .in_valid_in   (pend_valid),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (pend_byte),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (fifo_pop),
    .out_data_out  (fifo_out_data)
  );

  // ----------------------------------------------------------------
  // configuration clock sequencer
  // ----------------------------------------------------------------

  // next state: present byte, raise clock, lower clock, hold
  always @*
  begin
    next_state    = state;
    next_cnt      = cnt;
    next_cfg_byte = cfg_byte;
    next_cclk     = 1'b0;
    fifo_pop      = 1'b0;
    case (state)
      ST_IDLE:
      begin
        if (fifo_out_valid && !done_s)
        begin
          fifo_pop      = 1'b1;
          next_cfg_byte = fifo_out_data;
          next_cnt      = SETUP_CYC[3:0] - 4'h1;
          next_state    = ST_SETUP;
        end
      end
      ST_SETUP:
      begin
        if (cnt == 4'h0)
        begin
          next_cclk  = 1'b1;
          next_cnt   = HIGH_CYC[3:0] - 4'h1;
          next_state = ST_HIGH;
        end
        else
          next_cnt = cnt - 4'h1;
      end
      ST_HIGH:
      begin
        if (cnt == 4'h0)
        begin
          next_cnt   = HOLD_CYC[3:0] - 4'h1;
          next_state = ST_HOLD;
        end
        else
        begin
          next_cclk = 1'b1;
          next_cnt  = cnt - 4'h1;
        end
      end
      ST_HOLD:
      begin
        if (cnt == 4'h0)
          next_state = ST_IDLE;
        else
          next_cnt = cnt - 4'h1;
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // sequencer registers
  always @(posedge mclk_in)
  begin
    if (rst_in || flush)
    begin
      state         <= ST_IDLE;
      cnt           <= 4'h0;
      cfg_byte      <= 8'h00;
      fpga_cclk_out <= 1'b0;
    end
    else
    begin
      state         <= next_state;
      cnt           <= next_cnt;
      cfg_byte      <= next_cfg_byte;
      fpga_cclk_out <= next_cclk;
    end
  end

  // loader has work in hand
  always @(posedge mclk_in)
  begin
    if (rst_in)
      busy_out <= 1'b0;
    else
      busy_out <= pend_valid | fifo_out_valid | (state != ST_IDLE);
  end

  // ----------------------------------------------------------------
  // configuration control pins
  // ----------------------------------------------------------------

  // fixed levels and released pins follow completion
  always @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      fpga_tck_out           <= 1'b0;
      config_mode_select_out <= `MODE_SLAVE_PAR;
      fpga_progb_out         <= 1'b1;
      fceb_out               <= 1'b1;
      fceb_oe_out            <= 1'b1;
      fpga_csb_out           <= 1'b0;
      fpga_csb_oe_out        <= 1'b1;
      fpga_wrb_out           <= 1'b0;
      fpga_wrb_oe_out        <= 1'b1;
    end
    else
    begin
      fpga_tck_out           <= 1'b0;
      config_mode_select_out <= `MODE_SLAVE_PAR;
      fpga_progb_out         <= ppd_s[`PPD_PROG_BIT] | ~sync_ok;
      fceb_out               <= 1'b1;
      fceb_oe_out            <= ~done_s;
      fpga_csb_out           <= 1'b0;
      fpga_csb_oe_out        <= ~done_s;
      fpga_wrb_out           <= 1'b0;
      fpga_wrb_oe_out        <= ~done_s;
    end
  end

  // ----------------------------------------------------------------
  // fpga data pins and led segment
  // ----------------------------------------------------------------

  // config byte while configuring, decimal point or nothing after
  always @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      fpga_d_out    <= 8'h00;
      fpga_d_oe_out <= 8'hFF;
    end
    else if (!done_s)
    begin
      fpga_d_out    <= next_cfg_byte; // byte leads cclk by a cycle
      fpga_d_oe_out <= 8'hFF;
    end
    else if (fceb_s)
    begin
      fpga_d_out                <= 8'h00;
      fpga_d_out[`DP_SEG_BIT]   <= 1'b1;
      fpga_d_oe_out             <= 8'h00;
      fpga_d_oe_out[`DP_SEG_BIT] <= 1'b1;
    end
    else
    begin
      fpga_d_out    <= 8'h00;
      fpga_d_oe_out <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // user pass-through
  // ----------------------------------------------------------------

  // data lines to fpga, released while flash is enabled
  always @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      fpga_ppd_out    <= `PPD_INV_MASK;
      fpga_ppd_oe_out <= 1'b0;
    end
    else
    begin
      fpga_ppd_out    <= ppd_s ^ `PPD_INV_MASK;
      fpga_ppd_oe_out <= fceb_s;
    end
  end

  // status lines back to the host
  always @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      pps_out     <= 3'h0;
      pps_tdo_out <= 1'b0;
    end
    else
    begin
      pps_out     <= pps_s;
      pps_tdo_out <= tdo_s;
    end
  end

  // oscillator passes straight through, never retimed
  assign fpga_clk_out = osc_in;

endmodule // cfg_loader

// >>> cfg_loader_sva.sv
`timescale 1ns/1ps

// ----------------------------------------
// pin checks for the configuration loader
// ----------------------------------------
module cfg_loader_sva (
  input wire       mclk_in,
  input wire       rst_in,
  input wire [7:0] ppd_in,
  input wire [2:0] pps_out,
  input wire       pps_tdo_out,
  input wire       jtag_tdo_in,
  input wire       osc_in,
  input wire       fpga_clk_out,
  input wire       fpga_tck_out,
  input wire       fpga_cclk_out,
  input wire       fpga_progb_out,
  input wire       fpga_csb_out,
  input wire       fpga_csb_oe_out,
  input wire       fpga_wrb_out,
  input wire       fpga_wrb_oe_out,
  input wire       config_mode_select_out,
  input wire       fpga_done_in,
  input wire [7:0] fpga_d_out,
  input wire [7:0] fpga_d_oe_out,
  input wire [7:0] fpga_ppd_out,
  input wire       fpga_ppd_oe_out,
  input wire [2:0] fpga_pps_in,
  input wire       fceb_in,
  input wire       fceb_out,
  input wire       fceb_oe_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  a_scan_clk_low: assert property (!fpga_tck_out)
    else $error("scan clock not low");
  a_flash_held: assert property ($fell(fpga_done_in) |-> ##[1:4] (fceb_oe_out && fceb_out))
    else $error("flash enable not held high");
  a_flash_free: assert property ($rose(fpga_done_in) |-> ##[1:4] !fceb_oe_out)
    else $error("flash enable not released");
  a_mode_low: assert property (!config_mode_select_out)
    else $error("mode select not low");
  a_prog_follow: assert property ($fell(ppd_in[7]) |-> ##[1:4] !fpga_progb_out)
    else $error("reconfig request not passed");
  a_write_free: assert property ($rose(fpga_done_in) |-> ##[1:4] !(fpga_csb_oe_out || fpga_wrb_oe_out))
    else $error("select or strobe still driven");
  a_write_low: assert property (fpga_csb_oe_out |-> !fpga_csb_out && !fpga_wrb_out)
    else $error("select or strobe not low");
  a_clk_after_d0: assert property ($rose(ppd_in[0]) && ppd_in[7] && !fpga_done_in |-> ##[3:12] $rose(fpga_cclk_out))
    else $error("no config clock after strobe");
  a_byte_driven: assert property ($rose(fpga_cclk_out) |-> fpga_d_oe_out == 8'hFF && fpga_csb_oe_out)
    else $error("byte not driven at clock");
  a_dp_only: assert property ((fpga_done_in && fceb_in)[*5] |-> fpga_d_oe_out == 8'h02 && fpga_d_out[1])
    else $error("decimal point not alone");
  a_all_free: assert property ((fpga_done_in && !fceb_in)[*5] |-> fpga_d_oe_out == 8'h00 && !fpga_ppd_oe_out)
    else $error("lines not released");
  a_ppd_copy: assert property ($stable(ppd_in)[*5] |-> fpga_ppd_out == (ppd_in ^ 8'h03))
    else $error("data line copy wrong");
  a_status_route: assert property (($stable(fpga_pps_in) && $stable(jtag_tdo_in))[*5] |-> pps_out == fpga_pps_in && pps_tdo_out == jtag_tdo_in)
    else $error("status lines wrong");
  a_osc_pass: assert property (fpga_clk_out == osc_in)
    else $error("oscillator not passed");

  // main scenarios reached
  c_cfg_clock: cover property ($rose(fpga_cclk_out));
  c_done: cover property ($rose(fpga_done_in));
  c_flash_on: cover property (fpga_done_in && $fell(fceb_in));
endmodule // cfg_loader_sva

bind cfg_loader cfg_loader_sva chk (.*);

// >>> fpga_cfg_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// fpga slave parallel configuration port
// ----------------------------------------
module fpga_cfg_model #(
  parameter NBYTES = 4
) (
  // configuration pins
  input  wire       cclk_in,
  input  wire       progb_in,
  input  wire       csb_in,
  input  wire       csb_oe_in,
  input  wire [7:0] d_in,
  input  wire [7:0] d_oe_in,
  output reg        done_out,
  // flash enable wire
  input  wire       fceb_drv_in,
  input  wire       fceb_oe_in,
  input  wire       flash_on_in,
  output wire       fceb_wire_out
);
  reg [7:0] rx [0:7];
  reg [7:0] count;

  initial
  begin
    done_out = 1'b0;
    count    = 8'h00;
  end

  // low request restarts configuration
  always @(negedge progb_in)
  begin
    done_out <= 1'b0;
    count    <= 8'h00;
  end

  // take a byte on each clock while selected
  always @(posedge cclk_in)
    if (progb_in && !done_out && csb_oe_in && !csb_in && d_oe_in == 8'hFF)
    begin
      rx[count[2:0]] <= d_in;
      count          <= count + 8'h01;
      if (count == NBYTES - 1)
        done_out <= 1'b1;
    end

  // pull-up; flash enabled only after loader lets go
  assign fceb_wire_out = fceb_oe_in ? fceb_drv_in :
                         (flash_on_in && done_out) ? 1'b0 : 1'b1;
endmodule // fpga_cfg_model

// >>> cfg_loader_bench.sv
`timescale 1ns/1ps

module cfg_loader_bench;
  reg        mclk_in = 1'b0;
  reg        rst_in = 1'b1;
  reg  [7:0] ppd = 8'h81;
  reg  [2:0] sts = 3'h0;
  reg        tdo = 1'b0;
  reg        osc = 1'b0;
  reg        flash_on = 1'b0;
  integer    err_count = 0;
  integer    num_checks = 0;
  wire [2:0] pps;
  wire       pps_tdo, fclk, tck, cclk, progb, csb, csb_oe, wrb, wrb_oe, mode, done;
  wire [7:0] d, d_oe, fppd;
  wire       fppd_oe, fceb, fceb_drv, fceb_oe;
  wire       busy, ovr;

  // ----------------------------------------
  // clocks, design and partner
  // ----------------------------------------
  always #10 mclk_in = ~mclk_in;
  always #7 osc = ~osc;

  cfg_loader dut (.mclk_in(mclk_in), .rst_in(rst_in), .ppd_in(ppd), .pps_out(pps),
    .pps_tdo_out(pps_tdo), .jtag_tdo_in(tdo), .osc_in(osc), .fpga_clk_out(fclk),
    .fpga_tck_out(tck), .fpga_cclk_out(cclk), .fpga_progb_out(progb), .fpga_csb_out(csb),
    .fpga_csb_oe_out(csb_oe), .fpga_wrb_out(wrb), .fpga_wrb_oe_out(wrb_oe),
    .config_mode_select_out(mode), .fpga_done_in(done), .fpga_d_out(d), .fpga_d_oe_out(d_oe),
    .fpga_ppd_out(fppd), .fpga_ppd_oe_out(fppd_oe), .fpga_pps_in(sts), .fceb_in(fceb),
    .fceb_out(fceb_drv), .fceb_oe_out(fceb_oe), .busy_out(busy), .overrun_out(ovr));

  fpga_cfg_model fpga (.cclk_in(cclk), .progb_in(progb), .csb_in(csb), .csb_oe_in(csb_oe),
    .d_in(d), .d_oe_in(d_oe), .done_out(done), .fceb_drv_in(fceb_drv), .fceb_oe_in(fceb_oe),
    .flash_on_in(flash_on), .fceb_wire_out(fceb));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task cyc(input integer n);
    repeat (n) @(negedge mclk_in);
  endtask

  task chk(input [7:0] got, input [7:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
        err_count = err_count + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // host sends upper half on strobe fall, lower on rise
  task send_byte(input [7:0] b);
    begin
      ppd = {2'b10, b[7:4], 2'b01};
      cyc(1);
      ppd[0] = 1'b0;
      cyc(4);
      ppd[5:2] = b[3:0];
      cyc(1);
      ppd[0] = 1'b1;
      cyc(4);
    end
  endtask

  task stop_test;
    begin
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_fixed;
    begin
      chk(tck, 1'b0);
      chk(mode, 1'b0);
      chk({fceb_oe, fceb_drv}, 2'b11);
      chk({csb_oe, csb, wrb_oe, wrb}, 4'hA);
    end
  endtask

  task t_prog;
    begin
      ppd[7] = 1'b0;
      cyc(5);
      chk(progb, 1'b0);
      ppd[7] = 1'b1;
      cyc(5);
      chk(progb, 1'b1);
      chk(done, 1'b0);
    end
  endtask

  task t_load;
    reg [7:0] tbl [0:3];
    integer   i;
    begin
      tbl[0] = 8'hA5;
      tbl[1] = 8'h3C;
      tbl[2] = 8'h00;
      tbl[3] = 8'hFF;
      for (i = 0; i < 4; i = i + 1)
        send_byte(tbl[i]);
      chk(busy, 1'b1);
      cyc(4);
      for (i = 0; i < 4; i = i + 1)
        chk(fpga.rx[i], tbl[i]);
      cyc(5);
      chk(done, 1'b1);
      chk({busy, ovr}, 2'b00);
      chk({csb_oe, wrb_oe, fceb_oe}, 3'h0);
      chk(d_oe, 8'h02);
      chk(d[1], 1'b1);
      send_byte(8'h11);
      chk(fpga.count, 8'h04);
    end
  endtask

  task t_flash;
    begin
      flash_on = 1'b1;
      cyc(5);
      chk(fceb, 1'b0);
      chk(d_oe, 8'h00);
      chk(fppd_oe, 1'b0);
      flash_on = 1'b0;
      cyc(5);
      chk(d_oe, 8'h02);
      chk(fppd_oe, 1'b1);
    end
  endtask

  task t_pass;
    reg [7:0] p [0:2];
    integer   i;
    begin
      p[0] = 8'hC2;
      p[1] = 8'hFF;
      p[2] = 8'hBD;
      for (i = 0; i < 3; i = i + 1)
      begin
        ppd = p[i];
        sts = p[i][2:0];
        tdo = p[i][3];
        cyc(5);
        chk(fppd, p[i] ^ 8'h03);
        chk(pps, p[i][2:0]);
        chk(pps_tdo, p[i][3]);
        chk(fclk, osc);
      end
    end
  endtask

  // new request after completion restarts the loader
  task t_reconf;
    begin
      ppd[7] = 1'b0;
      cyc(6);
      chk({fceb_oe, fceb_drv, csb_oe, wrb_oe}, 4'hF);
      chk(d_oe, 8'hFF);
      ppd[7] = 1'b1;
      cyc(5);
      chk(done, 1'b0);
      send_byte(8'h5A);
      cyc(4);
      chk(fpga.rx[0], 8'h5A);
      chk(fpga.count, 8'h01);
      chk(ovr, 1'b0);
    end
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    cyc(4);
    t_fixed;
    rst_in = 1'b0;
    cyc(4);
    t_fixed;
    t_prog;
    t_load;
    t_flash;
    t_pass;
    t_reconf;
    stop_test;
  end

  initial
  begin
    #100000;
    err_count = err_count + 1;
    stop_test;
  end
endmodule // cfg_loader_bench
